// ---- common/ets_params.svh ----
// offsets, field positions, reset values and timing counts of the event timestamp block
// assumes: included by the package and the design; offsets are register indices, byte address = 4 * index
`ifndef ETS_PARAMS_SVH
`define ETS_PARAMS_SVH

// register indices
`define ETS_U1_CTL_IDX 11'h420
`define ETS_U1_S2_NSL_IDX 11'h434
`define ETS_U1_S2_NSH_IDX 11'h436
`define ETS_U1_S2_SL_IDX 11'h438
`define ETS_U1_S2_SH_IDX 11'h43a
`define ETS_U1_S2_SUB_IDX 11'h43c
`define ETS_U2_CTL_IDX 11'h440
`define ETS_U2_S1_NSL_IDX 11'h444
`define ETS_U2_S1_NSH_IDX 11'h446
`define ETS_U2_S1_SL_IDX 11'h448
`define ETS_U2_S1_SH_IDX 11'h44a
`define ETS_U2_S1_SUB_IDX 11'h44c

// control field positions
`define ETS_CTL_RISE_BIT 7
`define ETS_CTL_FALL_BIT 6
// upper nanosecond word field positions
`define ETS_NSH_EDGE_BIT 14
`define ETS_NSH_NS_MSB 13

// reset values
`define ETS_REC_RESET 16'h0000
`define ETS_CTL_RESET 2'h0

// which qualifying edge each unit records: unit 1 its second, unit 2 its first
`define ETS_U1_CAPTURE_AT 2'h1
`define ETS_U2_CAPTURE_AT 2'h0
`define ETS_EDGE_CNT_MAX 2'h2

// timing
`define ETS_CLK_PERIOD_NS 40
`define ETS_SLOT_NS 8
`define ETS_SLOTS_PER_TICK (`ETS_CLK_PERIOD_NS / `ETS_SLOT_NS)
`define ETS_SLOT_MAX 3'h4

`endif

// ---- common/ets_pkg.sv ----
// types of the event timestamp block
// assumes: nothing beyond the params header
`include "ets_params.svh"
package ets_pkg;
  typedef logic [29:0] ets_ns_t;
  typedef logic [31:0] ets_sec_t;
  typedef logic [2:0] ets_slot_t;
  typedef logic [1:0] ets_cnt_t;
  typedef enum logic [1:0] {
    ETS_HT_IDLE,
    ETS_HT_BUSY,
    ETS_HT_NONSEQ,
    ETS_HT_SEQ
  } ets_htrans_e;
endpackage

// ---- hdl/ets_sample2.sv ----
// two event timestamp units with capture records, reached as an AHB-Lite slave
// assumes: one 25 MHz clock, a free-running local time base on the same clock, event pins asynchronous
//
// Register access over AHB-Lite was left to the implementer.
`include "ets_params.svh"
module ets_sample2 (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [1:0] event_in,
  input wire logic [29:0] time_ns,
  input wire logic [31:0] time_sec,
  input wire logic [2:0] time_slot
);

  localparam int NU = 2;

  // clamp a raw slot code into the five meaningful slots
  function automatic ets_pkg::ets_slot_t ets_slot_clip(input logic [2:0] raw);
    ets_slot_clip = (raw > `ETS_SLOT_MAX) ? `ETS_SLOT_MAX : raw;
  endfunction

  // event pin synchronisers and edge detection
  logic [NU-1:0] ev_s1;
  logic [NU-1:0] ev_s2;
  logic [NU-1:0] ev_s3;
  logic [NU-1:0] rise;
  logic [NU-1:0] fall;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ev_s1 <= '0;
      ev_s2 <= '0;
      ev_s3 <= '0;
    end else begin
      ev_s1 <= event_in;
      ev_s2 <= ev_s1;
      ev_s3 <= ev_s2;
    end
  end

  // edges compare the second stage with the third, its one-cycle delayed copy
  assign rise = ev_s2 & ~ev_s3;
  assign fall = ~ev_s2 & ev_s3;

  // bus address phase capture
  logic wr_pend;
  logic [10:0] wr_idx;
  logic [31:0] rd_val;
  logic [31:0] next_hrdata;
  logic next_wr_pend;
  logic [10:0] next_wr_idx;
  logic addr_ok;
  logic [10:0] a_idx;

  assign addr_ok = hsel && hready && (htrans == ets_pkg::ETS_HT_NONSEQ || htrans == ets_pkg::ETS_HT_SEQ);
  assign a_idx = haddr[12:2];
  // zero wait state and always OKAY; hsize ignored, word transfers only
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // unit state
  logic [1:0] ctl [NU];
  ets_pkg::ets_cnt_t cnt [NU];
  ets_pkg::ets_ns_t rec_ns [NU];
  ets_pkg::ets_sec_t rec_sec [NU];
  ets_pkg::ets_slot_t rec_slot [NU];
  logic rec_edge [NU];
  logic [1:0] next_ctl [NU];
  ets_pkg::ets_cnt_t next_cnt [NU];
  ets_pkg::ets_ns_t next_rec_ns [NU];
  ets_pkg::ets_sec_t next_rec_sec [NU];
  ets_pkg::ets_slot_t next_rec_slot [NU];
  logic next_rec_edge [NU];
  logic [NU-1:0] qual;
  logic [NU-1:0] take;
  ets_pkg::ets_cnt_t cap_at [NU];

  // unit 1 records its second qualifying edge, unit 2 its first
  assign cap_at[0] = `ETS_U1_CAPTURE_AT;
  assign cap_at[1] = `ETS_U2_CAPTURE_AT;

  always_comb begin
    for (int u = 0; u < NU; u++) begin
      qual[u] = (rise[u] && ctl[u][1]) || (fall[u] && ctl[u][0]);
      take[u] = qual[u] && (cnt[u] == cap_at[u]);
      next_ctl[u] = ctl[u];
      next_cnt[u] = cnt[u];
      next_rec_ns[u] = rec_ns[u];
      next_rec_sec[u] = rec_sec[u];
      next_rec_slot[u] = rec_slot[u];
      next_rec_edge[u] = rec_edge[u];
      // count saturates so later edges never wrap back to a capture
      if (qual[u] && cnt[u] != `ETS_EDGE_CNT_MAX) begin
        next_cnt[u] = cnt[u] + 2'h1;
      end
      // a control write re-arms; an edge in the same cycle still counts
      if (wr_pend && wr_idx == (u == 0 ? `ETS_U1_CTL_IDX : `ETS_U2_CTL_IDX)) begin
        next_ctl[u] = {hwdata[`ETS_CTL_RISE_BIT], hwdata[`ETS_CTL_FALL_BIT]};
        next_cnt[u] = qual[u] ? 2'h1 : 2'h0;
      end
      if (take[u]) begin
        next_rec_ns[u] = time_ns;
        next_rec_sec[u] = time_sec;
        next_rec_slot[u] = ets_slot_clip(time_slot);
        next_rec_edge[u] = rise[u];
      end
    end
  end

  // synchronous reset clears records, enables and edge counts
  always_ff @(posedge clk) begin
    for (int u = 0; u < NU; u++) begin
      if (!reset_n) begin
        ctl[u] <= `ETS_CTL_RESET;
        cnt[u] <= 2'h0;
        rec_ns[u] <= '0;
        rec_sec[u] <= '0;
        rec_slot[u] <= '0;
        rec_edge[u] <= 1'b0;
      end else begin
        ctl[u] <= next_ctl[u];
        cnt[u] <= next_cnt[u];
        rec_ns[u] <= next_rec_ns[u];
        rec_sec[u] <= next_rec_sec[u];
        rec_slot[u] <= next_rec_slot[u];
        rec_edge[u] <= next_rec_edge[u];
      end
    end
  end

  // read decode
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (a_idx)
      `ETS_U1_CTL_IDX: rd_val[`ETS_CTL_RISE_BIT:`ETS_CTL_FALL_BIT] = ctl[0];
      `ETS_U1_S2_NSL_IDX: rd_val[15:0] = rec_ns[0][15:0];
      `ETS_U1_S2_NSH_IDX: rd_val[15:0] = {1'b0, rec_edge[0], rec_ns[0][29:16]};
      `ETS_U1_S2_SL_IDX: rd_val[15:0] = rec_sec[0][15:0];
      `ETS_U1_S2_SH_IDX: rd_val[15:0] = rec_sec[0][31:16];
      `ETS_U1_S2_SUB_IDX: rd_val[2:0] = rec_slot[0];
      `ETS_U2_CTL_IDX: rd_val[`ETS_CTL_RISE_BIT:`ETS_CTL_FALL_BIT] = ctl[1];
      `ETS_U2_S1_NSL_IDX: rd_val[15:0] = rec_ns[1][15:0];
      `ETS_U2_S1_NSH_IDX: rd_val[15:0] = {1'b0, rec_edge[1], rec_ns[1][29:16]};
      `ETS_U2_S1_SL_IDX: rd_val[15:0] = rec_sec[1][15:0];
      `ETS_U2_S1_SH_IDX: rd_val[15:0] = rec_sec[1][31:16];
      `ETS_U2_S1_SUB_IDX: rd_val[2:0] = rec_slot[1];
      // gaps and all else read zero
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_comb begin
    next_hrdata = hrdata;
    next_wr_pend = 1'b0;
    next_wr_idx = wr_idx;
    if (addr_ok && !hwrite) begin
      next_hrdata = rd_val;
    end
    // write data follows one cycle later, in the data phase
    if (addr_ok && hwrite) begin
      next_wr_pend = 1'b1;
      next_wr_idx = a_idx;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hrdata <= 32'h0000_0000;
      wr_pend <= 1'b0;
      wr_idx <= 11'h000;
    end else begin
      hrdata <= next_hrdata;
      wr_pend <= next_wr_pend;
      wr_idx <= next_wr_idx;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // an enabled edge that meets the unit's capture count
  sequence u0_take_s;
    rise[0] || fall[0] ##0 take[0];
  endsequence

  sequence u1_take_s;
    rise[1] || fall[1] ##0 take[1];
  endsequence

  // record holds the time base of the detecting cycle
  sequence u0_loaded_s;
    rec_ns[0] == $past(time_ns) && rec_sec[0] == $past(time_sec);
  endsequence

  sequence u1_loaded_s;
    rec_ns[1] == $past(time_ns) && rec_sec[1] == $past(time_sec);
  endsequence

  // read address phase of one index
  sequence rd_addr_s(logic [10:0] idx);
    addr_ok && !hwrite && a_idx == idx;
  endsequence

  // capture and hold
  u0_capture_a: assert property (u0_take_s |=> u0_loaded_s)
    else $error("unit 1 record not loaded from time base");
  u1_capture_a: assert property (u1_take_s |=> u1_loaded_s)
    else $error("unit 2 record not loaded from time base");
  u0_edge_a: assert property (take[0] |=> rec_edge[0] == $past(rise[0]))
    else $error("unit 1 edge polarity wrong");
  u1_edge_a: assert property (take[1] ##1 1'b1 |-> rec_edge[1] == $past(rise[1]))
    else $error("unit 2 edge polarity wrong");
  slot_range_a: assert property (rec_slot[0] <= `ETS_SLOT_MAX && rec_slot[1] <= `ETS_SLOT_MAX)
    else $error("slot code out of range");
  slot_copy_a: assert property (take[0] && time_slot <= `ETS_SLOT_MAX |=> rec_slot[0] == $past(time_slot))
    else $error("slot code not recorded");
  hold_rec_a: assert property (!take[0] |=> $stable(rec_ns[0]) && $stable(rec_sec[0]))
    else $error("unit 1 record changed without edge");
  hold_fields_a: assert property (!take[0] |=> $stable(rec_slot[0]) && $stable(rec_edge[0]))
    else $error("unit 1 slot or edge changed without edge");
  hold_u1_a: assert property (!take[1] |=> $stable(rec_ns[1]) && $stable(rec_sec[1]))
    else $error("unit 2 record changed without edge");
  hold_u1_fields_a: assert property (!take[1] |=> $stable(rec_slot[1]) && $stable(rec_edge[1]))
    else $error("unit 2 slot or edge changed without edge");

  // edge gating and counting
  gate_rise_a: assert property (rise[0] && !ctl[0][1] |-> !take[0])
    else $error("disabled rising edge captured");
  gate_fall_a: assert property (fall[0] && !ctl[0][0] |-> !take[0])
    else $error("disabled falling edge captured");
  u1_gate_a: assert property (rise[1] && !ctl[1][1] |-> !take[1])
    else $error("unit 2 disabled rising edge captured");
  second_only_a: assert property (take[0] |-> cnt[0] == 2'h1 && qual[0])
    else $error("unit 1 captured other than second edge");
  later_edge_a: assert property (cnt[0] == `ETS_EDGE_CNT_MAX |-> !take[0])
    else $error("unit 1 captured after its second edge");
  first_only_a: assert property (take[1] |-> cnt[1] == 2'h0 && qual[1])
    else $error("unit 2 captured other than first edge");
  u1_later_a: assert property (cnt[1] != 2'h0 |-> !take[1])
    else $error("unit 2 captured after its first edge");
  ctl_write_a: assert property (wr_pend && wr_idx == `ETS_U1_CTL_IDX
    |=> ctl[0] == {$past(hwdata[`ETS_CTL_RISE_BIT]), $past(hwdata[`ETS_CTL_FALL_BIT])})
    else $error("unit 1 enable write lost");

  // register reads
  nsl_read_a: assert property (addr_ok && !hwrite && a_idx == `ETS_U1_S2_NSL_IDX
    |=> hrdata == {16'h0000, $past(rec_ns[0][15:0])})
    else $error("low nanosecond read wrong");
  nsh_read_a: assert property (addr_ok && !hwrite && a_idx == `ETS_U1_S2_NSH_IDX
    |=> hrdata[15] == 1'b0 && hrdata[13:0] == $past(rec_ns[0][29:16]))
    else $error("upper nanosecond read wrong");
  edge_read_a: assert property (rd_addr_s(`ETS_U1_S2_NSH_IDX)
    |=> hrdata[14] == $past(rec_edge[0]))
    else $error("edge flag read wrong");
  sl_read_a: assert property (rd_addr_s(`ETS_U1_S2_SL_IDX)
    |=> hrdata == {16'h0000, $past(rec_sec[0][15:0])})
    else $error("seconds low read wrong");
  sec_read_a: assert property (addr_ok && !hwrite && a_idx == `ETS_U1_S2_SH_IDX
    |=> hrdata[15:0] == $past(rec_sec[0][31:16]))
    else $error("seconds high read wrong");
  sub_read_a: assert property (rd_addr_s(`ETS_U1_S2_SUB_IDX)
    |=> hrdata == {29'h0, $past(rec_slot[0])})
    else $error("slot field read wrong");
  u1_nsl_read_a: assert property (rd_addr_s(`ETS_U2_S1_NSL_IDX)
    |=> hrdata == {16'h0000, $past(rec_ns[1][15:0])})
    else $error("unit 2 low nanosecond read wrong");
  gap_read_a: assert property (addr_ok && !hwrite && a_idx >= 11'h42e && a_idx <= 11'h433
    |=> hrdata == 32'h0000_0000)
    else $error("reserved gap read nonzero");
  gap_mid_a: assert property (addr_ok && !hwrite && a_idx >= 11'h43e && a_idx <= 11'h43f
    |=> hrdata == 32'h0000_0000)
    else $error("reserved gap after unit 1 read nonzero");
  gap_high_a: assert property (addr_ok && !hwrite && a_idx >= 11'h44e && a_idx <= 11'h453
    |=> hrdata == 32'h0000_0000)
    else $error("reserved gap after unit 2 read nonzero");

endmodule

// ---- verification/ets_event_src.sv ----
// model of the two external event pins feeding the timestamp units
// assumes: bench clock; each level held long enough for the synchroniser
module ets_event_src (
  input wire logic clk,
  output logic [1:0] event_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial event_in = 2'h0;
  // change one pin after an edge, then hold it
  task automatic set_pin(input int unit, input logic lvl);
    @(posedge clk);
    event_in[unit] <= lvl;
    repeat (6) @(posedge clk);
  endtask
endmodule

// ---- verification/tb_top.sv ----
// bench for the timestamp record block over AHB-Lite
// assumes: zero wait state slave, time base held steady around each event
`include "ets_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans, event_in;
  logic [2:0] hsize, time_slot;
  logic [31:0] haddr, hwdata, hrdata, time_sec;
  logic [29:0] time_ns;
  int n_errors, n_compared;
  ets_sample2 uut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .event_in(event_in), .time_ns(time_ns), .time_sec(time_sec),
    .time_slot(time_slot));
  ets_event_src src (.clk(clk), .event_in(event_in));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic give_verdict();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      n_errors++;
      $display("[FAIL] hreadyout expected 1 seen %b", hreadyout);
      give_verdict();
    end
  endtask
  task automatic bus(input logic [10:0] idx, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    htrans <= ets_pkg::ETS_HT_NONSEQ;
    haddr <= {19'h0, idx, 2'h0};
    hwrite <= wr;
    wait_ready();
    htrans <= ets_pkg::ETS_HT_IDLE;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input string what, input logic [10:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    bus(idx, 1'b0, 32'h0, d);
    chk(what, exp, d);
  endtask
  task automatic wr(input logic [10:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    bus(idx, 1'b1, wd, d);
    chk("write resp", 32'h0, {31'h0, hresp});
  endtask
  task automatic rec_chk(input logic [10:0] b, input logic [29:0] ns, input logic [31:0] s,
    input logic [2:0] sl, input logic e);
    rd_chk("ns low", b, {16'h0, ns[15:0]});
    rd_chk("ns high", b + 11'h2, {16'h0, 1'b0, e, ns[29:16]});
    rd_chk("sec low", b + 11'h4, {16'h0, s[15:0]});
    rd_chk("sec high", b + 11'h6, {16'h0, s[31:16]});
    rd_chk("slot", b + 11'h8, {29'h0, sl});
  endtask
  task automatic set_time(input logic [29:0] ns, input logic [31:0] s, input logic [2:0] sl);
    @(posedge clk);
    time_ns <= ns;
    time_sec <= s;
    time_slot <= sl;
  endtask
  task automatic t_reset();
    rec_chk(`ETS_U1_S2_NSL_IDX, 30'h0, 32'h0, 3'h0, 1'b0);
    rd_chk("gap 430", 11'h430, 32'h0);
    rd_chk("gap 43e", 11'h43e, 32'h0);
    rd_chk("gap 44e", 11'h44e, 32'h0);
  endtask
  task automatic t_rise();
    wr(`ETS_U1_CTL_IDX, 32'h80);
    rd_chk("unit1 ctl", `ETS_U1_CTL_IDX, 32'h80);
    set_time(30'h2abc1234, 32'h11112222, 3'h1);
    src.set_pin(0, 1'b1);
    src.set_pin(0, 1'b0);
    set_time(30'h3bcd5678, 32'hdead0001, 3'h3);
    src.set_pin(0, 1'b1);
    rec_chk(`ETS_U1_S2_NSL_IDX, 30'h3bcd5678, 32'hdead0001, 3'h3, 1'b1);
  endtask
  task automatic t_fall();
    wr(`ETS_U1_CTL_IDX, 32'h40);
    src.set_pin(0, 1'b0);
    src.set_pin(0, 1'b1);
    set_time(30'h0155aa33, 32'h8765fedc, 3'h7);
    src.set_pin(0, 1'b0);
    rec_chk(`ETS_U1_S2_NSL_IDX, 30'h0155aa33, 32'h8765fedc, `ETS_SLOT_MAX, 1'b0);
    wr(`ETS_U1_S2_NSL_IDX, 32'hffff);
    rd_chk("ro ns low", `ETS_U1_S2_NSL_IDX, 32'haa33);
  endtask
  task automatic t_unit2();
    wr(`ETS_U2_CTL_IDX, 32'hc0);
    rd_chk("unit2 ctl", `ETS_U2_CTL_IDX, 32'hc0);
    set_time(30'h12345678, 32'h0badcafe, 3'h2);
    src.set_pin(1, 1'b1);
    rec_chk(`ETS_U2_S1_NSL_IDX, 30'h12345678, 32'h0badcafe, 3'h2, 1'b1);
    set_time(30'h00000001, 32'h00000001, 3'h0);
    src.set_pin(1, 1'b0);
    rec_chk(`ETS_U2_S1_NSL_IDX, 30'h12345678, 32'h0badcafe, 3'h2, 1'b1);
  endtask
  task automatic t_midreset();
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rec_chk(`ETS_U1_S2_NSL_IDX, 30'h0, 32'h0, 3'h0, 1'b0);
    rec_chk(`ETS_U2_S1_NSL_IDX, 30'h0, 32'h0, 3'h0, 1'b0);
    rd_chk("ctl after reset", `ETS_U1_CTL_IDX, 32'h0);
  endtask
  initial begin
    n_errors = 0;
    n_compared = 0;
    reset_n = 1'b0;
    hsel = 1'b1;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    time_ns = 30'h0;
    time_sec = 32'h0;
    time_slot = 3'h0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_rise();
    t_fall();
    t_unit2();
    t_midreset();
    give_verdict();
  end
endmodule
